/* File: pkg/mpuo_pkg.sv */
// Constants of the motion profile parameter bank: object indices, sub-entries, presets and field layouts.
package mpuo_pkg;
	localparam logic [15:0] IDX_JERK_CONV = 16'h60A2;
	localparam logic [15:0] IDX_PROFILE_JERK = 16'h60A4;
	localparam logic [15:0] IDX_POS_UNIT = 16'h60A8;
	localparam logic [15:0] IDX_VEL_UNIT = 16'h60A9;
	localparam logic [15:0] IDX_POS_OFFSET = 16'h60B0;
	localparam logic [15:0] IDX_VEL_OFFSET = 16'h60B1;
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_ONE = 8'h01;
	localparam logic [7:0] SUB_TWO = 8'h02;
	localparam logic [7:0] SUB_THREE = 8'h03;
	localparam logic [7:0] SUB_FOUR = 8'h04;
	localparam logic [7:0] JERK_CONV_HIGHEST_SUB = 8'h02;
	localparam logic [7:0] PROFILE_JERK_HIGHEST_SUB = 8'h04;
	localparam logic [31:0] RST_JERK_CONV = 32'h00000001;
	localparam logic [31:0] RST_PROFILE_JERK = 32'h000003E8;
	localparam logic [31:0] RST_POS_UNIT = 32'hFF410000;
	localparam logic [31:0] RST_VEL_UNIT = 32'h00B44700;
	localparam logic [31:0] RST_OFFSET = 32'h00000000;
	localparam logic [31:0] MASK_ALL = 32'hFFFFFFFF;
	localparam logic [31:0] MASK_POS_UNIT = 32'hFFFF0000;
	localparam logic [31:0] MASK_VEL_UNIT = 32'hFFFFFF00;
	localparam int UNIT_CODE_LSB = 16;
	localparam int UNIT_EXP_LSB = 24;
	localparam int TIME_CODE_LSB = 8;
	localparam int FIELD_W = 8;
	localparam int NUM_JERK = 4;
	typedef enum logic [1:0] {
		MPUO_LOAD = 2'b00,
		MPUO_RUN = 2'b01,
		MPUO_STORE = 2'b11
	} mpuo_conv_state_t;
endpackage

/* File: verilog/mpuo_entry.sv */
// One writable 32-bit dictionary entry with preset value and a mask of the bits that may be written.
`timescale 1ns/1ps
module mpuo_entry #(
	parameter logic [31:0] RESET_VALUE = 32'h00000000,
	parameter logic [31:0] WRITE_MASK = 32'hFFFFFFFF
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic we,
	input wire logic [31:0] wdata,
	output logic [31:0] q
);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			q <= RESET_VALUE;
		end else if (we) begin
			q <= wdata & WRITE_MASK;
		end
	end
endmodule // mpuo_entry

/* File: verilog/mpuo_divider.sv */
// Sequential restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
module mpuo_divider #(
	parameter int W = 64,
	parameter int DW = 32
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [W-1:0] dividend,
	input wire logic [DW-1:0] divisor,
	output logic done,
	output logic [W-1:0] quotient
);
	localparam int CW = $clog2(W + 1);
	logic [DW:0] rem;
	logic [CW-1:0] cnt;
	logic busy;
	logic [DW:0] trial;

	// A zero divisor yields all ones, which later saturates instead of hanging.
	assign trial = {rem[DW-1:0], quotient[W-1]};

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rem <= '0;
			quotient <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				rem <= '0;
				quotient <= dividend;
				cnt <= CW'(W);
				busy <= 1'b1;
			end else if (busy) begin
				if (trial >= {1'b0, divisor}) begin
					rem <= trial - {1'b0, divisor};
					quotient <= {quotient[W-2:0], 1'b1};
				end else begin
					rem <= trial;
					quotient <= {quotient[W-2:0], 1'b0};
				end
				cnt <= cnt - CW'(1);
				if (cnt == CW'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule // mpuo_divider

/* File: verilog/mpuo_bank.sv */
// Motion profile parameter bank: dictionary access port, jerk conversion and setpoint offsets.
`timescale 1ns/1ps
module mpuo_bank (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic od_req,
	input wire logic od_write,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_subindex,
	input wire logic [31:0] od_wdata,
	output logic od_ack,
	output logic od_abort,
	output logic [31:0] od_rdata,
	input wire logic [31:0] pos_setpoint,
	input wire logic [31:0] vel_setpoint,
	output logic [31:0] pos_setpoint_adj,
	output logic [31:0] vel_setpoint_adj,
	output logic [31:0] jerk_begin_accel_int,
	output logic [31:0] jerk_begin_brake_int,
	output logic [31:0] jerk_end_accel_int,
	output logic [31:0] jerk_end_brake_int,
	output logic [3:0] jerk_limit_en,
	output logic jerk_int_valid,
	output logic [7:0] pos_unit_code,
	output logic [7:0] pos_unit_exp,
	output logic [7:0] vel_time_code,
	output logic [7:0] vel_pos_code,
	output logic [7:0] vel_unit_exp
);
	logic [31:0] jerk_num;
	logic [31:0] jerk_den;
	logic [31:0] jerk_lim [mpuo_pkg::NUM_JERK];
	logic [31:0] pos_unit;
	logic [31:0] vel_unit;
	logic [31:0] pos_offset;
	logic [31:0] vel_offset;
	logic wr;
	logic we_num;
	logic we_den;
	logic [3:0] we_jerk;
	logic we_pos_unit;
	logic we_vel_unit;
	logic we_pos_off;
	logic we_vel_off;
	logic next_abort;
	logic [31:0] next_rdata;

	assign wr = od_req & od_write;

	// Write decode: the sub-entry counts are read-only, so writing them is refused.
	always_comb begin
		we_num = 1'b0;
		we_den = 1'b0;
		we_jerk = 4'h0;
		we_pos_unit = 1'b0;
		we_vel_unit = 1'b0;
		we_pos_off = 1'b0;
		we_vel_off = 1'b0;
		if (od_index == mpuo_pkg::IDX_JERK_CONV) begin
			we_num = wr & (od_subindex == mpuo_pkg::SUB_ONE);
			we_den = wr & (od_subindex == mpuo_pkg::SUB_TWO);
		end else if (od_index == mpuo_pkg::IDX_PROFILE_JERK) begin
			we_jerk[0] = wr & (od_subindex == mpuo_pkg::SUB_ONE);
			we_jerk[1] = wr & (od_subindex == mpuo_pkg::SUB_TWO);
			we_jerk[2] = wr & (od_subindex == mpuo_pkg::SUB_THREE);
			we_jerk[3] = wr & (od_subindex == mpuo_pkg::SUB_FOUR);
		end else if (od_index == mpuo_pkg::IDX_POS_UNIT) begin
			we_pos_unit = wr & (od_subindex == mpuo_pkg::SUB_COUNT);
		end else if (od_index == mpuo_pkg::IDX_VEL_UNIT) begin
			we_vel_unit = wr & (od_subindex == mpuo_pkg::SUB_COUNT);
		end else if (od_index == mpuo_pkg::IDX_POS_OFFSET) begin
			we_pos_off = wr & (od_subindex == mpuo_pkg::SUB_COUNT);
		end else if (od_index == mpuo_pkg::IDX_VEL_OFFSET) begin
			we_vel_off = wr & (od_subindex == mpuo_pkg::SUB_COUNT);
		end
	end

	// Read decode and refusal of unknown objects, unknown sub-entries and read-only writes.
	always_comb begin
		next_rdata = 32'h00000000;
		next_abort = 1'b0;
		if (od_index == mpuo_pkg::IDX_JERK_CONV) begin
			if (od_subindex == mpuo_pkg::SUB_COUNT) begin
				next_rdata = {24'h000000, mpuo_pkg::JERK_CONV_HIGHEST_SUB};
				next_abort = od_write;
			end else if (od_subindex == mpuo_pkg::SUB_ONE) begin
				next_rdata = jerk_num;
			end else if (od_subindex == mpuo_pkg::SUB_TWO) begin
				next_rdata = jerk_den;
			end else begin
				next_abort = 1'b1;
			end
		end else if (od_index == mpuo_pkg::IDX_PROFILE_JERK) begin
			if (od_subindex == mpuo_pkg::SUB_COUNT) begin
				next_rdata = {24'h000000, mpuo_pkg::PROFILE_JERK_HIGHEST_SUB};
				next_abort = od_write;
			end else if (od_subindex == mpuo_pkg::SUB_ONE) begin
				next_rdata = jerk_lim[0];
			end else if (od_subindex == mpuo_pkg::SUB_TWO) begin
				next_rdata = jerk_lim[1];
			end else if (od_subindex == mpuo_pkg::SUB_THREE) begin
				next_rdata = jerk_lim[2];
			end else if (od_subindex == mpuo_pkg::SUB_FOUR) begin
				next_rdata = jerk_lim[3];
			end else begin
				next_abort = 1'b1;
			end
		end else if (od_subindex != mpuo_pkg::SUB_COUNT) begin
			next_abort = 1'b1;
		end else if (od_index == mpuo_pkg::IDX_POS_UNIT) begin
			next_rdata = pos_unit;
		end else if (od_index == mpuo_pkg::IDX_VEL_UNIT) begin
			next_rdata = vel_unit;
		end else if (od_index == mpuo_pkg::IDX_POS_OFFSET) begin
			next_rdata = pos_offset;
		end else if (od_index == mpuo_pkg::IDX_VEL_OFFSET) begin
			next_rdata = vel_offset;
		end else begin
			next_abort = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			od_ack <= 1'b0;
			od_abort <= 1'b0;
			od_rdata <= 32'h00000000;
		end else begin
			od_ack <= od_req;
			od_abort <= od_req & next_abort;
			if (od_req & ~od_write & ~next_abort) begin
				od_rdata <= next_rdata;
			end
		end
	end

	mpuo_entry #(.RESET_VALUE(mpuo_pkg::RST_JERK_CONV), .WRITE_MASK(mpuo_pkg::MASK_ALL)) u_num (
		.sys_clk(sys_clk), .srst(srst), .we(we_num), .wdata(od_wdata), .q(jerk_num)
	);
	mpuo_entry #(.RESET_VALUE(mpuo_pkg::RST_JERK_CONV), .WRITE_MASK(mpuo_pkg::MASK_ALL)) u_den (
		.sys_clk(sys_clk), .srst(srst), .we(we_den), .wdata(od_wdata), .q(jerk_den)
	);
	for (genvar g = 0; g < mpuo_pkg::NUM_JERK; g++) begin : g_jerk
		mpuo_entry #(.RESET_VALUE(mpuo_pkg::RST_PROFILE_JERK), .WRITE_MASK(mpuo_pkg::MASK_ALL)) u_lim (
			.sys_clk(sys_clk), .srst(srst), .we(we_jerk[g]), .wdata(od_wdata), .q(jerk_lim[g])
		);
	end
	// Reserved bytes are masked at the write so they can never read back nonzero.
	mpuo_entry #(.RESET_VALUE(mpuo_pkg::RST_POS_UNIT), .WRITE_MASK(mpuo_pkg::MASK_POS_UNIT)) u_pos_unit (
		.sys_clk(sys_clk), .srst(srst), .we(we_pos_unit), .wdata(od_wdata), .q(pos_unit)
	);
	mpuo_entry #(.RESET_VALUE(mpuo_pkg::RST_VEL_UNIT), .WRITE_MASK(mpuo_pkg::MASK_VEL_UNIT)) u_vel_unit (
		.sys_clk(sys_clk), .srst(srst), .we(we_vel_unit), .wdata(od_wdata), .q(vel_unit)
	);
	mpuo_entry #(.RESET_VALUE(mpuo_pkg::RST_OFFSET), .WRITE_MASK(mpuo_pkg::MASK_ALL)) u_pos_off (
		.sys_clk(sys_clk), .srst(srst), .we(we_pos_off), .wdata(od_wdata), .q(pos_offset)
	);
	mpuo_entry #(.RESET_VALUE(mpuo_pkg::RST_OFFSET), .WRITE_MASK(mpuo_pkg::MASK_ALL)) u_vel_off (
		.sys_clk(sys_clk), .srst(srst), .we(we_vel_off), .wdata(od_wdata), .q(vel_offset)
	);

	// Unit fields are fixed slices of the stored words.
	assign pos_unit_code = pos_unit[mpuo_pkg::UNIT_CODE_LSB +: mpuo_pkg::FIELD_W];
	assign pos_unit_exp = pos_unit[mpuo_pkg::UNIT_EXP_LSB +: mpuo_pkg::FIELD_W];
	assign vel_time_code = vel_unit[mpuo_pkg::TIME_CODE_LSB +: mpuo_pkg::FIELD_W];
	assign vel_pos_code = vel_unit[mpuo_pkg::UNIT_CODE_LSB +: mpuo_pkg::FIELD_W];
	assign vel_unit_exp = vel_unit[mpuo_pkg::UNIT_EXP_LSB +: mpuo_pkg::FIELD_W];

	// Offsets wrap on overflow; the setpoint range is the caller's concern.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pos_setpoint_adj <= 32'h00000000;
			vel_setpoint_adj <= 32'h00000000;
		end else begin
			pos_setpoint_adj <= pos_setpoint + pos_offset;
			vel_setpoint_adj <= vel_setpoint + vel_offset;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			jerk_limit_en <= 4'h0;
		end else begin
			for (int i = 0; i < mpuo_pkg::NUM_JERK; i++) begin
				jerk_limit_en[i] <= (jerk_lim[i] != 32'h00000000);
			end
		end
	end

	// Conversion sequencer: one shared divider walks the four limits round robin.
	mpuo_pkg::mpuo_conv_state_t state;
	logic [1:0] sel;
	logic div_start;
	logic div_done;
	logic [63:0] product;
	logic [63:0] quotient;
	logic [31:0] quot_sat;
	logic [mpuo_pkg::NUM_JERK-1:0] conv_seen;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			product <= 64'h0000000000000000;
		end else begin
			product <= 64'(jerk_num) * 64'(jerk_lim[sel]);
		end
	end

	mpuo_divider #(.W(64), .DW(32)) u_div (
		.sys_clk(sys_clk),
		.srst(srst),
		.start(div_start),
		.dividend(product),
		.divisor(jerk_den),
		.done(div_done),
		.quotient(quotient)
	);

	// Results that exceed 32 bits, including a zero divisor, clamp to full scale.
	assign quot_sat = (quotient[63:32] != 32'h00000000) ? 32'hFFFFFFFF : quotient[31:0];

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= mpuo_pkg::MPUO_LOAD;
			sel <= 2'h0;
			div_start <= 1'b0;
		end else begin
			div_start <= 1'b0;
			case (state)
				mpuo_pkg::MPUO_LOAD: begin
					div_start <= 1'b1;
					state <= mpuo_pkg::MPUO_RUN;
				end
				mpuo_pkg::MPUO_RUN: begin
					if (div_done) begin
						state <= mpuo_pkg::MPUO_STORE;
					end
				end
				default: begin
					sel <= sel + 2'h1;
					state <= mpuo_pkg::MPUO_LOAD;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			jerk_begin_accel_int <= 32'h00000000;
			jerk_begin_brake_int <= 32'h00000000;
			jerk_end_accel_int <= 32'h00000000;
			jerk_end_brake_int <= 32'h00000000;
			conv_seen <= 4'h0;
			jerk_int_valid <= 1'b0;
		end else begin
			if (state == mpuo_pkg::MPUO_STORE) begin
				case (sel)
					2'h0: jerk_begin_accel_int <= quot_sat;
					2'h1: jerk_begin_brake_int <= quot_sat;
					2'h2: jerk_end_accel_int <= quot_sat;
					default: jerk_end_brake_int <= quot_sat;
				endcase
				conv_seen[sel] <= 1'b1;
			end
			jerk_int_valid <= &conv_seen;
		end
	end
endmodule // mpuo_bank

/* File: testbench/mpuo_host.sv */
// Host master model that issues dictionary accesses to the bank.
`timescale 1ns/1ps
module mpuo_host (
	input wire logic sys_clk,
	output logic od_req,
	output logic od_write,
	output logic [15:0] od_index,
	output logic [7:0] od_subindex,
	output logic [31:0] od_wdata
);
	initial begin
		od_req = 1'b0;
		od_write = 1'b0;
		od_index = 16'h0000;
		od_subindex = 8'h00;
		od_wdata = 32'h0;
	end
	// Each request is held until the next call or release_bus, so calls may follow each other on consecutive cycles.
	task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
		@(negedge sys_clk);
		od_req = 1'b1;
		od_write = w;
		od_index = i;
		od_subindex = s;
		od_wdata = d;
	endtask
	// Released lines show inverted values so that a stale request can never pass for a live one.
	task automatic release_bus();
		@(negedge sys_clk);
		od_req = 1'b0;
		od_write = ~od_write;
		od_index = ~od_index;
		od_subindex = ~od_subindex;
		od_wdata = ~od_wdata;
	endtask
endmodule // mpuo_host

/* File: testbench/mpuo_bank_properties.sv */
// Concurrent checks on the ports of the motion profile parameter bank.
`timescale 1ns/1ps
module mpuo_bank_properties (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic od_req,
	input wire logic od_write,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_subindex,
	input wire logic [31:0] od_wdata,
	input wire logic od_ack,
	input wire logic od_abort,
	input wire logic [31:0] od_rdata,
	input wire logic [31:0] pos_setpoint,
	input wire logic [31:0] vel_setpoint,
	input wire logic [31:0] pos_setpoint_adj,
	input wire logic [31:0] vel_setpoint_adj,
	input wire logic [31:0] jerk_begin_accel_int,
	input wire logic [31:0] jerk_begin_brake_int,
	input wire logic [31:0] jerk_end_accel_int,
	input wire logic [31:0] jerk_end_brake_int,
	input wire logic [3:0] jerk_limit_en,
	input wire logic jerk_int_valid,
	input wire logic [7:0] pos_unit_code,
	input wire logic [7:0] pos_unit_exp,
	input wire logic [7:0] vel_time_code,
	input wire logic [7:0] vel_pos_code,
	input wire logic [7:0] vel_unit_exp
);
	logic p_rd;
	logic [15:0] p_idx;
	logic [7:0] p_sub;
	logic rd_ok;
	always_ff @(posedge sys_clk) begin
		p_rd <= od_req && !od_write;
		p_idx <= od_index;
		p_sub <= od_subindex;
	end
	assign rd_ok = od_ack && !od_abort && p_rd;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_ack_after_req: assert property (od_req |=> od_ack)
		else $error("no answer one cycle after a request");
	a_ack_has_req: assert property (od_ack |-> $past(od_req))
		else $error("answer without a request");
	a_highest_sub: assert property (rd_ok && p_sub == 8'h00 && p_idx == 16'h60A4 |-> od_rdata == 32'h4)
		else $error("wrong highest sub-entry count");
	a_pos_fields: assert property (rd_ok && p_idx == 16'h60A8 |-> od_rdata[31:16] == {pos_unit_exp, pos_unit_code})
		else $error("position unit fields differ from word");
	a_vel_fields: assert property (rd_ok && p_idx == 16'h60A9 |-> od_rdata[31:8] == {vel_unit_exp, vel_pos_code, vel_time_code})
		else $error("velocity unit fields differ from word");
	a_reserved_zero: assert property (rd_ok |-> !(p_idx == 16'h60A8 && |od_rdata[15:0]) && !(p_idx == 16'h60A9 && |od_rdata[7:0]))
		else $error("reserved unit bits read nonzero");
	a_jerk_en_match: assert property (rd_ok && p_idx == 16'h60A4 && p_sub != 8'h00 |-> jerk_limit_en[p_sub[1:0] - 2'h1] == |od_rdata)
		else $error("jerk limit enable disagrees with stored jerk");
	a_unit_presets: assert property ($fell(srst) |-> {pos_unit_exp, pos_unit_code, vel_unit_exp, vel_pos_code, vel_time_code} == 40'hFF4100B447)
		else $error("unit fields not preset after reset");
	a_pos_offset: assert property (!$past(srst) && !$past(srst, 2) && !$past(od_req, 2) |-> pos_setpoint_adj - $past(pos_setpoint) == $past(pos_setpoint_adj) - $past(pos_setpoint, 2))
		else $error("position offset changed without a write");
	a_vel_offset: assert property (!$past(srst) && !$past(srst, 2) && !$past(od_req, 2) |-> vel_setpoint_adj - $past(vel_setpoint) == $past(vel_setpoint_adj) - $past(vel_setpoint, 2))
		else $error("velocity offset changed without a write");
	c_write: cover property (od_req && od_write ##1 od_ack && !od_abort);
	c_abort: cover property (od_abort);
	c_conv: cover property ($rose(jerk_int_valid));
endmodule // mpuo_bank_properties
bind mpuo_bank mpuo_bank_properties i_chk (.*);

/* File: testbench/mpuo_bank_test.sv */
// Self-checking bench for the motion profile parameter bank.
`timescale 1ns/1ps
module mpuo_bank_test;
	typedef struct {logic ab; logic rd; logic [31:0] d;} mpuo_exp_t;
	logic sys_clk;
	logic srst;
	logic od_req, od_write, od_ack, od_abort, jerk_int_valid;
	logic [15:0] od_index;
	logic [7:0] od_subindex;
	logic [31:0] od_wdata, od_rdata, pos_setpoint, vel_setpoint, pos_setpoint_adj, vel_setpoint_adj, ja, jb, r, po, vo;
	logic [31:0] jbb, jea;
	logic [3:0] jerk_limit_en;
	logic [63:0] p;
	int n_fail = 0;
	int tests_run = 0;
	mpuo_exp_t q[$];
	mpuo_exp_t e;
	mpuo_host i_host (.sys_clk(sys_clk), .od_req(od_req), .od_write(od_write), .od_index(od_index),
		.od_subindex(od_subindex), .od_wdata(od_wdata));
	mpuo_bank i_dut (.sys_clk(sys_clk), .srst(srst), .od_req(od_req), .od_write(od_write), .od_index(od_index),
		.od_subindex(od_subindex), .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata),
		.pos_setpoint(pos_setpoint), .vel_setpoint(vel_setpoint), .pos_setpoint_adj(pos_setpoint_adj),
		.vel_setpoint_adj(vel_setpoint_adj), .jerk_begin_accel_int(ja), .jerk_begin_brake_int(jbb),
		.jerk_end_accel_int(jea), .jerk_end_brake_int(jb), .jerk_limit_en(jerk_limit_en),
		.jerk_int_valid(jerk_int_valid), .pos_unit_code(), .pos_unit_exp(), .vel_time_code(), .vel_pos_code(),
		.vel_unit_exp());
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic c_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		if (q.size() != 0) n_fail++;
		$display("checks %0d errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
		input logic ab, input logic [31:0] x);
		q.push_back('{ab, !w, x});
		i_host.access(w, i, s, d);
	endtask
	always @(negedge sys_clk) begin
		if (od_ack === 1'b1) begin
			if (q.size() == 0) begin
				c_word(32'h1, 32'h0);
			end else begin
				e = q.pop_front();
				c_word({31'h0, od_abort}, {31'h0, e.ab});
				if (e.rd && !e.ab) c_word(od_rdata, e.d);
			end
		end
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_fail++;
		end_sim();
	end
	initial begin
		srst = 1'b1;
		pos_setpoint = 32'h0;
		vel_setpoint = 32'h0;
		r = 32'hAF290620;
		repeat (12) @(negedge sys_clk);
		srst = 1'b0;
		acc(1'b0, 16'h60A2, 8'h00, 32'h0, 1'b0, 32'h2);
		acc(1'b0, 16'h60A2, 8'h01, 32'h0, 1'b0, 32'h1);
		acc(1'b0, 16'h60A2, 8'h02, 32'h0, 1'b0, 32'h1);
		acc(1'b0, 16'h60A4, 8'h00, 32'h0, 1'b0, 32'h4);
		for (int k = 1; k < 5; k++) acc(1'b0, 16'h60A4, 8'(k), 32'h0, 1'b0, 32'h3E8);
		acc(1'b0, 16'h60A8, 8'h00, 32'h0, 1'b0, 32'hFF410000);
		acc(1'b0, 16'h60A9, 8'h00, 32'h0, 1'b0, 32'h00B44700);
		acc(1'b0, 16'h60B0, 8'h00, 32'h0, 1'b0, 32'h0);
		acc(1'b0, 16'h60B1, 8'h00, 32'h0, 1'b0, 32'h0);
		acc(1'b1, 16'h60A2, 8'h00, 32'h7, 1'b1, 32'h0);
		acc(1'b1, 16'h60A4, 8'h00, 32'h7, 1'b1, 32'h0);
		acc(1'b0, 16'h60A2, 8'h03, 32'h0, 1'b1, 32'h0);
		acc(1'b0, 16'h60A4, 8'h05, 32'h0, 1'b1, 32'h0);
		acc(1'b0, 16'h60A9, 8'h01, 32'h0, 1'b1, 32'h0);
		acc(1'b0, 16'h60B2, 8'h00, 32'h0, 1'b1, 32'h0);
		acc(1'b0, 16'h60A4, 8'h00, 32'h0, 1'b0, 32'h4);
		r = lfsr(r);
		acc(1'b1, 16'h60A8, 8'h00, r, 1'b0, 32'h0);
		acc(1'b0, 16'h60A8, 8'h00, 32'h0, 1'b0, r & 32'hFFFF0000);
		acc(1'b1, 16'h60A9, 8'h00, ~r, 1'b0, 32'h0);
		acc(1'b0, 16'h60A9, 8'h00, 32'h0, 1'b0, ~r & 32'hFFFFFF00);
		r = lfsr(r);
		acc(1'b1, 16'h60A2, 8'h01, 32'h3, 1'b0, 32'h0);
		acc(1'b1, 16'h60A2, 8'h02, 32'h2, 1'b0, 32'h0);
		acc(1'b1, 16'h60A4, 8'h02, 32'h0, 1'b0, 32'h0);
		acc(1'b1, 16'h60A4, 8'h04, r & 32'h00FFFFFF, 1'b0, 32'h0);
		acc(1'b0, 16'h60A4, 8'h02, 32'h0, 1'b0, 32'h0);
		i_host.release_bus();
		// The converter visits each limit in turn, so allow two full rounds.
		repeat (600) @(negedge sys_clk);
		p = {32'h0, r & 32'h00FFFFFF} * 64'h3 / 64'h2;
		c_word(ja, 32'h5DC);
		c_word(jb, p[31:0]);
		c_word(jbb, 32'h0);
		c_word(jea, 32'h5DC);
		c_word({28'h0, jerk_limit_en}, 32'hD);
		c_word({31'h0, jerk_int_valid}, 32'h1);
		po = lfsr(r);
		vo = lfsr(po);
		acc(1'b1, 16'h60B0, 8'h00, po, 1'b0, 32'h0);
		acc(1'b1, 16'h60B1, 8'h00, vo, 1'b0, 32'h0);
		acc(1'b0, 16'h60B0, 8'h00, 32'h0, 1'b0, po);
		acc(1'b0, 16'h60B1, 8'h00, 32'h0, 1'b0, vo);
		i_host.release_bus();
		repeat (3) @(negedge sys_clk);
		r = vo;
		for (int k = 0; k < 20; k++) begin
			r = lfsr(r);
			pos_setpoint = r;
			vel_setpoint = ~r;
			@(negedge sys_clk);
			c_word(pos_setpoint_adj, pos_setpoint + po);
			c_word(vel_setpoint_adj, vel_setpoint + vo);
		end
		repeat (3) @(negedge sys_clk);
		end_sim();
	end
endmodule // mpuo_bank_test
